/* hdl/ftac_pkg.sv */
// Purpose: shared constants and carriers for the flash table access block
// Assumes: 8-bit special register space with 12-bit addresses
// Notes:   the control register offset is fixed, the others are placed nearby
package ftac_pkg;
    // register offsets in special register space
    localparam logic [11:0] FTAC_OFS_CTRL   = 12'hfa6;
    localparam logic [11:0] FTAC_OFS_KEY    = 12'hfa7;
    localparam logic [11:0] FTAC_OFS_LATCH  = 12'hff5;
    localparam logic [11:0] FTAC_OFS_PTR_L  = 12'hff6;
    localparam logic [11:0] FTAC_OFS_PTR_H  = 12'hff7;
    localparam logic [11:0] FTAC_OFS_PTR_U  = 12'hff8;
    // control field positions
    localparam int FTAC_BIT_START = 1;
    localparam int FTAC_BIT_PROGRAM_WRITE_ENABLE  = 2;
    localparam int FTAC_BIT_ERR   = 3;
    localparam int FTAC_BIT_ERASE = 4;
    localparam int FTAC_BIT_WIDTH = 5;
    // reset values
    localparam logic [7:0]  FTAC_RST_BYTE = 8'h00;
    localparam logic [21:0] FTAC_RST_PTR  = 22'h000000;
    // unlock key bytes
    localparam logic [7:0]  FTAC_KEY_1 = 8'h55;
    localparam logic [7:0]  FTAC_KEY_2 = 8'haa;
    // holding block size and row and word write lengths
    localparam int          FTAC_HOLD_N  = 64;
    localparam logic [6:0]  FTAC_ROW_LEN = 7'h40;
    localparam logic [6:0]  FTAC_WRD_LEN = 7'h02;
    // code substituted for fetches that cannot be served
    localparam logic [15:0] FTAC_NOP_WORD = 16'h0000;
    // default self-timed durations in cycles
    localparam int FTAC_PROG_CYC  = 20000;
    localparam int FTAC_ERASE_CYC = 40000;

    // pointer update modes
    typedef enum logic [1:0] {
        FTAC_PTR_KEEP    = 2'h0,
        FTAC_PTR_POSTINC = 2'h1,
        FTAC_PTR_POSTDEC = 2'h2,
        FTAC_PTR_PREINC  = 2'h3
    } ftac_mode_t;

    // table instruction from the core
    typedef struct packed {
        logic       valid;
        logic       write;
        ftac_mode_t mode;
    } ftac_tbl_t;

    // special register access from the core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } ftac_sfr_t;
endpackage

/* hdl/ftac_top.sv */
// Purpose: table read/write and self-timed erase/program sequencer
// Assumes: core drives one table op or one register access per cycle
// Notes:   array read port has one cycle of latency, same clock
`timescale 1ns/1ps
`default_nettype none
module ftac_top
    import ftac_pkg::*;
#(
    parameter int PROG_CYC  = FTAC_PROG_CYC,
    parameter int ERASE_CYC = FTAC_ERASE_CYC
) (
    // clock, reset, enable
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic        i_clk_en,
    input  wire logic        i_abort,
    // core side
    input  wire ftac_sfr_t   i_sfr,
    output logic [7:0]       o_sfr_rdata,
    input  wire ftac_tbl_t   i_tbl,
    output logic             o_tbl_done,
    output logic             o_fetch_stall,
    input  wire logic [15:0] i_fetch_word,
    output logic [15:0]      o_fetch_word,
    // array side
    output logic             o_pm_rd,
    output logic [21:0]      o_pm_rd_addr,
    input  wire logic [15:0] i_pm_rdata,
    output logic             o_pm_wr,
    output logic             o_pm_erase,
    output logic [21:0]      o_pm_wr_addr,
    output logic [7:0]       o_pm_wr_data
);

    ////////////////////////////////////////////////////////////////////
    // types and helpers

    typedef enum logic [2:0] {
        S_IDLE   = 3'b001,
        S_STREAM = 3'b010,
        S_WAIT   = 3'b100
    } ftac_state_t;

    typedef enum logic [2:0] {
        K_NONE  = 3'b001,
        K_HALF  = 3'b010,
        K_ARMED = 3'b100
    } ftac_key_t;

    localparam logic [19:0] PROG_CNT  = 20'(PROG_CYC - 1);
    localparam logic [19:0] ERASE_CNT = 20'(ERASE_CYC - 1);

    // step keeps the top pointer bit
    function automatic logic [21:0] ftac_step(input logic [21:0] p,
                                              input logic        up);
        logic [20:0] low;
        low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
        return {p[21], low};
    endfunction

    function automatic logic ftac_hit(input ftac_sfr_t s,
                                      input logic [11:0] a);
        return s.addr == a;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state declarations

    ftac_state_t st_r;
    ftac_key_t   key_r;
    logic [21:0] ptr_r;
    logic [7:0]  latch_r;
    logic [7:0]  hold_r [FTAC_HOLD_N];
    logic        start_r;
    logic        program_write_enable_r;
    logic        err_r;
    logic        erase_r;
    logic        width_r;
    logic [19:0] tmr_r;
    logic [6:0]  left_r;
    logic [21:0] base_r;
    logic [5:0]  idx_r;
    logic        rd_pend_r;
    logic        rd_lsb_r;

    logic        busy;
    logic        tbl_go;
    logic        ctl_wr;
    logic        go_req;
    logic        go_ok;
    logic [21:0] ea;

    assign busy   = (st_r != S_IDLE);
    // table ops are ignored while busy; the core is stalled then
    assign tbl_go = i_tbl.valid && !busy;
    assign ctl_wr = i_sfr.wr && ftac_hit(i_sfr, FTAC_OFS_CTRL);
    assign go_req = ctl_wr && i_sfr.wdata[FTAC_BIT_START] && !start_r;
    // start only right after the key pair
    // start only with write enable set
    // erase of config space would act as bulk, refused
    assign go_ok  = go_req && (key_r == K_ARMED)
                    && i_sfr.wdata[FTAC_BIT_PROGRAM_WRITE_ENABLE]
                    && !(i_sfr.wdata[FTAC_BIT_ERASE] && ptr_r[21]);
    assign ea = (i_tbl.mode == FTAC_PTR_PREINC) ? ftac_step(ptr_r, 1'b1)
                                                 : ptr_r;

    ////////////////////////////////////////////////////////////////////
    // unlock sequencer: any other register write breaks the chain

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            key_r <= K_NONE;
        end else if (i_clk_en) begin
            if (i_abort) begin
                key_r <= K_NONE;
            end else if (i_sfr.wr) begin
                if (ftac_hit(i_sfr, FTAC_OFS_KEY)) begin
                    if (i_sfr.wdata == FTAC_KEY_1) begin
                        key_r <= K_HALF;
                    end else if (i_sfr.wdata == FTAC_KEY_2
                                 && key_r == K_HALF) begin
                        key_r <= K_ARMED;
                    end else begin
                        key_r <= K_NONE;
                    end
                end else begin
                    key_r <= K_NONE; // one try per unlock
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register bits

    // enable and mode bits are plain software bits, cleared at reset
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            program_write_enable_r  <= 1'b0;
            width_r <= 1'b0;
        end else if (i_clk_en) begin
            if (i_abort) begin
                program_write_enable_r  <= 1'b0;
                width_r <= 1'b0;
            end else if (ctl_wr) begin
                program_write_enable_r  <= i_sfr.wdata[FTAC_BIT_PROGRAM_WRITE_ENABLE];
                width_r <= i_sfr.wdata[FTAC_BIT_WIDTH];
            end
        end
    end

    // erase select, cleared by hardware after an erase; set wins
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            erase_r <= 1'b0;
        end else if (i_clk_en) begin
            if (i_abort) begin
                erase_r <= 1'b0;
            end else if (ctl_wr) begin
                erase_r <= i_sfr.wdata[FTAC_BIT_ERASE];
            end else if (st_r == S_WAIT && tmr_r == 20'h0 && erase_r) begin
                erase_r <= 1'b0;
            end
        end
    end

    // start: software sets, hardware clears at the end
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            start_r <= 1'b0;
        end else if (i_clk_en) begin
            if (i_abort) begin
                start_r <= 1'b0;
            end else if (go_ok) begin
                start_r <= 1'b1;
            end else if (st_r == S_WAIT && tmr_r == 20'h0) begin
                start_r <= 1'b0;
            end
        end
    end

    // error: set by any start attempt while start is clear, cleared on normal finish
    // an abort leaves it set so software can see the cut-short cycle
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            err_r <= 1'b0;
        end else if (i_clk_en) begin
            if (go_req) begin
                err_r <= 1'b1;
            end else if (i_abort && busy) begin
                err_r <= 1'b1;
            end else if (st_r == S_WAIT && tmr_r == 20'h0) begin
                err_r <= 1'b0;
            end else if (ctl_wr) begin
                err_r <= i_sfr.wdata[FTAC_BIT_ERR];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // table pointer

    // three byte registers, top register holds six bits
    // automatic update after each table op except in keep mode
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr_r <= FTAC_RST_PTR;
        end else if (i_clk_en) begin
            if (tbl_go) begin
                case (i_tbl.mode)
                    FTAC_PTR_KEEP:    ptr_r <= ptr_r;
                    FTAC_PTR_POSTINC: ptr_r <= ftac_step(ptr_r, 1'b1);
                    FTAC_PTR_POSTDEC: ptr_r <= ftac_step(ptr_r, 1'b0);
                    FTAC_PTR_PREINC:  ptr_r <= ftac_step(ptr_r, 1'b1);
                    default:          ptr_r <= ptr_r;
                endcase
            end else if (i_sfr.wr && !busy) begin
                if (ftac_hit(i_sfr, FTAC_OFS_PTR_L)) begin
                    ptr_r[7:0] <= i_sfr.wdata;
                end
                if (ftac_hit(i_sfr, FTAC_OFS_PTR_H)) begin
                    ptr_r[15:8] <= i_sfr.wdata;
                end
                if (ftac_hit(i_sfr, FTAC_OFS_PTR_U)) begin
                    ptr_r[21:16] <= i_sfr.wdata[5:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // table read path

    // pointer with bit 0 cleared addresses the array read
    // no alignment check on the byte address
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pm_rd      <= 1'b0;
            o_pm_rd_addr <= FTAC_RST_PTR;
            rd_pend_r    <= 1'b0;
            rd_lsb_r     <= 1'b0;
        end else if (i_clk_en) begin
            o_pm_rd   <= tbl_go && !i_tbl.write;
            rd_pend_r <= tbl_go && !i_tbl.write;
            if (tbl_go && !i_tbl.write) begin
                o_pm_rd_addr <= {ea[21:1], 1'b0};
                rd_lsb_r     <= ea[0];
            end
        end
    end

    // the byte latch is the only data path
    // bit 0 selects high or low byte of the word
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            latch_r <= FTAC_RST_BYTE;
        end else if (i_clk_en) begin
            if (rd_pend_r) begin
                latch_r <= rd_lsb_r ? i_pm_rdata[15:8] : i_pm_rdata[7:0];
            end else if (i_sfr.wr && ftac_hit(i_sfr, FTAC_OFS_LATCH)) begin
                latch_r <= i_sfr.wdata;
            end
        end
    end

    // done pulse: read one cycle after the array answers, write one after
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tbl_done <= 1'b0;
        end else if (i_clk_en) begin
            o_tbl_done <= tbl_go && i_tbl.write || rd_pend_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // holding registers

    // table write only fills a holding register
    // low pointer bits pick the holding slot
    // no clear at reset or after programming
    always_ff @(posedge i_clock) begin
        if (i_clk_en && tbl_go && i_tbl.write) begin
            hold_r[ea[5:0]] <= latch_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // long operation sequencer

    // program streams 64 or 2 bytes, erase goes straight to the wait; then wait out the timer
    // the timer or an abort ends the cycle
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r   <= S_IDLE;
            tmr_r  <= 20'h0;
            left_r <= 7'h0;
            base_r <= FTAC_RST_PTR;
            idx_r  <= 6'h0;
        end else if (i_clk_en) begin
            if (i_abort) begin
                st_r <= S_IDLE;
            end else begin
                case (st_r)
                    S_IDLE: begin
                        if (go_ok && i_sfr.wdata[FTAC_BIT_ERASE]) begin
                            base_r <= {ptr_r[21:10], 10'h000};
                            tmr_r  <= ERASE_CNT;
                            st_r   <= S_WAIT;
                        end else if (go_ok) begin
                            if (i_sfr.wdata[FTAC_BIT_WIDTH]) begin
                                base_r <= {ptr_r[21:1], 1'b0};
                                idx_r  <= {ptr_r[5:1], 1'b0};
                                left_r <= FTAC_WRD_LEN;
                            end else begin
                                base_r <= {ptr_r[21:6], 6'h00};
                                idx_r  <= 6'h00;
                                left_r <= FTAC_ROW_LEN;
                            end
                            tmr_r <= PROG_CNT;
                            st_r  <= S_STREAM;
                        end
                    end
                    S_STREAM: begin
                        idx_r  <= idx_r + 6'h01;
                        left_r <= left_r - 7'h01;
                        if (left_r == 7'h01) begin
                            st_r <= S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        if (tmr_r == 20'h0) begin
                            st_r <= S_IDLE;
                        end else begin
                            tmr_r <= tmr_r - 20'h00001;
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // array write strobes, address and data
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pm_wr      <= 1'b0;
            o_pm_erase   <= 1'b0;
            o_pm_wr_addr <= FTAC_RST_PTR;
            o_pm_wr_data <= FTAC_RST_BYTE;
        end else if (i_clk_en) begin
            o_pm_erase <= go_ok && i_sfr.wdata[FTAC_BIT_ERASE] && !i_abort;
            o_pm_wr    <= (st_r == S_STREAM) && !i_abort;
            if (go_ok && i_sfr.wdata[FTAC_BIT_ERASE]) begin
                o_pm_wr_addr <= {ptr_r[21:10], 10'h000};
            end else if (st_r == S_STREAM) begin
                o_pm_wr_addr <= {base_r[21:6], idx_r};
                o_pm_wr_data <= hold_r[idx_r];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fetch gating

    // stall covers the whole long cycle
    // no-op code fed while the array is unavailable
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fetch_stall <= 1'b0;
            o_fetch_word  <= FTAC_NOP_WORD;
        end else if (i_clk_en) begin
            o_fetch_stall <= go_ok || (busy && !i_abort
                             && !(st_r == S_WAIT && tmr_r == 20'h0));
            o_fetch_word  <= busy ? FTAC_NOP_WORD : i_fetch_word;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read-back

    // unlock key reads as zero; unmapped also zero
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sfr_rdata <= FTAC_RST_BYTE;
        end else if (i_clk_en) begin
            o_sfr_rdata <= FTAC_RST_BYTE;
            if (i_sfr.rd) begin
                case (i_sfr.addr)
                    FTAC_OFS_CTRL:  o_sfr_rdata <= {2'b00, width_r, erase_r,
                                                    err_r, program_write_enable_r, start_r,
                                                    1'b0};
                    FTAC_OFS_LATCH: o_sfr_rdata <= latch_r;
                    FTAC_OFS_PTR_L: o_sfr_rdata <= ptr_r[7:0];
                    FTAC_OFS_PTR_H: o_sfr_rdata <= ptr_r[15:8];
                    FTAC_OFS_PTR_U: o_sfr_rdata <= {2'b00, ptr_r[21:16]};
                    default:        o_sfr_rdata <= FTAC_RST_BYTE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    a_start_unlocked: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        $rose(start_r) |-> $past(key_r) == K_ARMED)
        else $error("start without unlock pair");

    a_start_program_write_enable: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        $rose(start_r) |-> program_write_enable_r)
        else $error("start without write enable");

    a_start_err: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        $rose(start_r) |-> err_r)
        else $error("error flag not set on start");

    a_stall_busy: assert property (
        @(posedge i_clock) disable iff (!i_reset_n || i_abort)
        $rose(start_r) |-> o_fetch_stall && busy)
        else $error("no fetch stall during long cycle");

    a_key_zero: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clk_en && i_sfr.rd && i_sfr.addr == FTAC_OFS_KEY
        |=> o_sfr_rdata == 8'h00)
        else $error("unlock key read not zero");

    a_ptr_top: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clk_en && tbl_go |=> ptr_r[21] == $past(ptr_r[21]))
        else $error("pointer top bit moved");

    a_erase_block: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        o_pm_erase |-> o_pm_wr_addr[9:0] == 10'h000)
        else $error("erase address not block aligned");

    a_timer_end: assert property (
        @(posedge i_clock) disable iff (!i_reset_n || i_abort)
        i_clk_en && st_r == S_WAIT && tmr_r == 20'h0
        |=> !start_r && !err_r && st_r == S_IDLE)
        else $error("timer expiry did not end cycle");

    a_read_byte: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clk_en && rd_pend_r |=> latch_r == ($past(rd_lsb_r)
            ? $past(i_pm_rdata[15:8]) : $past(i_pm_rdata[7:0])))
        else $error("wrong byte latched");

endmodule // ftac_top
`default_nettype wire

/* testbench/ftac_pm_model.sv */
// Purpose: program array model and strobe monitor
// Assumes: read data answers within the request cycle, taken at the next edge
// Notes:   idle data toggles so a stale word never passes
`timescale 1ns/1ps
`default_nettype none
module ftac_pm_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    // array port
    input  wire logic        i_pm_rd,
    input  wire logic [21:0] i_pm_rd_addr,
    output logic      [15:0] o_pm_rdata,
    input  wire logic        i_pm_wr,
    input  wire logic        i_pm_erase,
    input  wire logic [21:0] i_pm_wr_addr,
    input  wire logic [7:0]  i_pm_wr_data,
    // observed traffic
    output int               o_n_wr,
    output int               o_n_er,
    output logic      [21:0] o_wr_addr,
    output logic      [7:0]  o_wr_data
);
    logic [15:0] idle_r;
    // idle pattern flips every cycle
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) idle_r <= 16'h0000;
        else idle_r <= ~idle_r;
    end
    // the sequencer latches at the edge that ends the request cycle;
    // low byte is word index, high byte its inverse
    assign o_pm_rdata = i_pm_rd ? {~i_pm_rd_addr[8:1], i_pm_rd_addr[8:1]} : idle_r;
    // count strobes; erase shares the write address
    always_ff @(posedge i_clock) begin
        if (i_pm_wr || i_pm_erase) o_wr_addr <= i_pm_wr_addr;
        if (i_pm_wr) o_wr_data <= i_pm_wr_data;
        if (i_pm_wr) o_n_wr <= o_n_wr + 1;
        if (i_pm_erase) o_n_er <= o_n_er + 1;
    end
endmodule // ftac_pm_model
`default_nettype wire

/* testbench/ftac_top_bench.sv */
// Purpose: self-checking bench for the flash table sequencer
// Assumes: short timers, clock enable high, one warm reset at the end
// Notes:   rows walk the pointer modes, long cycles follow
`timescale 1ns/1ps
`default_nettype none
module ftac_top_bench;
    import ftac_pkg::*;
    typedef struct packed {
        logic [21:0] ptr;
        ftac_mode_t  mode;
        logic [7:0]  dat;
        logic [21:0] nxt;
    } ftac_row_t;
    // pointer, mode, latch byte, pointer after
    ftac_row_t rows [6] = '{
        '{22'h000010, FTAC_PTR_KEEP, 8'h08, 22'h000010},
        '{22'h000011, FTAC_PTR_POSTINC, 8'hf7, 22'h000012},
        '{22'h000100, FTAC_PTR_POSTDEC, 8'h80, 22'h0000ff},
        '{22'h0000ff, FTAC_PTR_PREINC, 8'h80, 22'h000100},
        '{22'h3fffff, FTAC_PTR_POSTINC, 8'h00, 22'h200000},
        '{22'h200003, FTAC_PTR_POSTDEC, 8'hfe, 22'h200002}};
    logic        i_clock, i_reset_n, o_tbl_done, o_fetch_stall, o_pm_rd, o_pm_wr, o_pm_erase;
    logic        i_abort;
    ftac_sfr_t   i_sfr;
    ftac_tbl_t   i_tbl;
    logic [7:0]  o_sfr_rdata, o_pm_wr_data, rv, wd;
    logic [15:0] o_fetch_word, i_pm_rdata;
    logic [21:0] o_pm_rd_addr, o_pm_wr_addr, wa, pv;
    int          mismatches, n_checks, nw, ne, w0, e0;
    ftac_top #(.PROG_CYC(20), .ERASE_CYC(30)) dut (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_abort(i_abort),
        .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .i_tbl(i_tbl), .o_tbl_done(o_tbl_done),
        .o_fetch_stall(o_fetch_stall), .i_fetch_word(16'h1234), .o_fetch_word(o_fetch_word),
        .o_pm_rd(o_pm_rd), .o_pm_rd_addr(o_pm_rd_addr), .i_pm_rdata(i_pm_rdata),
        .o_pm_wr(o_pm_wr), .o_pm_erase(o_pm_erase), .o_pm_wr_addr(o_pm_wr_addr),
        .o_pm_wr_data(o_pm_wr_data));
    ftac_pm_model pm (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pm_rd(o_pm_rd),
        .i_pm_rd_addr(o_pm_rd_addr), .o_pm_rdata(i_pm_rdata), .i_pm_wr(o_pm_wr),
        .i_pm_erase(o_pm_erase), .i_pm_wr_addr(o_pm_wr_addr), .i_pm_wr_data(o_pm_wr_data),
        .o_n_wr(nw), .o_n_er(ne), .o_wr_addr(wa), .o_wr_data(wd));
    // free-running core clock
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        mismatches++;
        $display("CHECK FAILED at %0t: no completion", $time);
        wrap_up();
    endtask
    // strobes stay up until the next call overrides them
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_sfr = '{1'b1, 1'b0, a, d};
        @(negedge i_clock);
    endtask
    task automatic rd(input logic [11:0] a);
        i_sfr = '{1'b0, 1'b1, a, 8'h00};
        @(negedge i_clock);
        rv = o_sfr_rdata;
    endtask
    task automatic idle;
        i_sfr = '0;
        @(negedge i_clock);
    endtask
    task automatic setp(input logic [21:0] p);
        wr(FTAC_OFS_PTR_U, {2'b00, p[21:16]});
        wr(FTAC_OFS_PTR_H, p[15:8]);
        wr(FTAC_OFS_PTR_L, p[7:0]);
    endtask
    task automatic getp;
        rd(FTAC_OFS_PTR_U);
        pv[21:16] = rv[5:0];
        rd(FTAC_OFS_PTR_H);
        pv[15:8] = rv;
        rd(FTAC_OFS_PTR_L);
        pv[7:0] = rv;
    endtask
    // a table op must not share a cycle with a register write
    task automatic top(input logic w, input ftac_mode_t m);
        i_sfr = '0;
        i_tbl = '{1'b1, w, m};
        @(negedge i_clock);
        i_tbl = '0;
        for (int k = 0; o_tbl_done !== 1'b1; k++) begin
            if (k == 4) tmo();
            @(negedge i_clock);
        end
    endtask
    // unlock keys then control byte
    task automatic go(input logic [7:0] c);
        w0 = nw;
        e0 = ne;
        wr(FTAC_OFS_KEY, FTAC_KEY_1);
        wr(FTAC_OFS_KEY, FTAC_KEY_2);
        wr(FTAC_OFS_CTRL, c);
        idle();
    endtask
    task automatic drain;
        for (int k = 0; o_fetch_stall !== 1'b0; k++) begin
            if (k == 300) tmo();
            @(negedge i_clock);
        end
        rd(FTAC_OFS_CTRL);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_sfr = '0;
        i_tbl = '0;
        i_abort = 1'b0;
        i_reset_n = 1'b0;
        repeat (12) @(negedge i_clock);
        i_reset_n = 1'b1;
        rd(FTAC_OFS_CTRL);
        chk(rv, 8'h00);
        wr(FTAC_OFS_KEY, FTAC_KEY_1);
        rd(FTAC_OFS_KEY);
        chk(rv, 8'h00);
        foreach (rows[r]) begin
            setp(rows[r].ptr);
            top(1'b0, rows[r].mode);
            rd(FTAC_OFS_LATCH);
            chk(rv, rows[r].dat);
            getp();
            chk(pv, rows[r].nxt);
        end
        $display("test pointer rows done");
        wr(FTAC_OFS_LATCH, 8'h5a);
        setp(22'h000402);
        top(1'b1, FTAC_PTR_POSTINC);
        wr(FTAC_OFS_LATCH, 8'ha5);
        top(1'b1, FTAC_PTR_KEEP);
        chk(nw, 0);
        go(8'h26);
        chk({o_fetch_stall, o_fetch_word}, 17'h10000);
        rd(FTAC_OFS_CTRL);
        chk(rv, 8'h2e);
        wr(FTAC_OFS_CTRL, 8'h2c);
        rd(FTAC_OFS_CTRL);
        chk(rv[1], 1'b1);
        drain();
        chk(rv, 8'h24);
        chk(nw - w0, 2);
        chk({wa, wd}, {22'h000403, 8'ha5});
        go(8'h26);
        drain();
        chk({wa, wd}, {22'h000403, 8'ha5});
        go(8'h06);
        drain();
        chk(rv, 8'h04);
        chk(nw - w0, 64);
        $display("test program done");
        setp(22'h000abc);
        go(8'h16);
        drain();
        chk(rv, 8'h04);
        chk(ne - e0, 1);
        chk(wa, 22'h000800);
        $display("test erase done");
        go(8'h02);
        rd(FTAC_OFS_CTRL);
        chk(rv, 8'h08);
        wr(FTAC_OFS_CTRL, 8'h06);
        rd(FTAC_OFS_CTRL);
        chk(rv, 8'h0c);
        setp(22'h200000);
        go(8'h16);
        rd(FTAC_OFS_CTRL);
        chk({rv[1], o_fetch_stall, ne - e0}, 34'h0);
        $display("test refusals done");
        // warm reset cuts a program cycle; error must outlive the timer
        go(8'h26);
        i_abort = 1'b1;
        @(negedge i_clock);
        i_abort = 1'b0;
        repeat (40) @(negedge i_clock);
        rd(FTAC_OFS_CTRL);
        chk({rv, o_fetch_stall}, 9'h010);
        $display("test abort done");
        wrap_up();
    end
endmodule // ftac_top_bench
`default_nettype wire
